/* core/fram_host.sv */
// Host controller that drives the ferroelectric SRAM-style memory port.
`timescale 1ns/1ps
module fram_host #(
    parameter int ROW_W = 14,
    parameter int COL_W = 3,
    parameter int DATA_W = 8,
    parameter int POWERUP_CYCLES = fram_host_pkg::POWERUP_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic reqValid,
    output logic reqReady,
    input wire logic reqWrite,
    input wire logic [ROW_W+COL_W-1:0] reqAddr,
    input wire logic [DATA_W-1:0] reqWdata,
    output logic rspValid,
    output logic [DATA_W-1:0] rspRdata,
    output logic powerSafe,
    output logic select_n,
    output logic select_hi,
    output logic strobe_n,
    output logic outputGate_n,
    output logic [ROW_W-1:0] row_address_upper,
    output logic [COL_W-1:0] page_column_address,
    input wire logic [DATA_W-1:0] dataIn,
    output logic [DATA_W-1:0] dataOut,
    output logic dataOe
);

    typedef struct packed {
        fram_host_pkg::state_t state;
        logic [15:0] cnt;
        logic selN;
        logic selHi;
        logic strobeN;
        logic gateN;
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] dOut;
        logic dOe;
        logic isWrite;
        logic pageHit;
        logic [DATA_W-1:0] rdata;
        logic rspValid;
        logic [DATA_W-1:0] dqS1;
        logic [DATA_W-1:0] dqS2;
        logic [3:0] rowAge;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = '{state: fram_host_pkg::ST_POWERUP, selN: 1'b1,
        strobeN: 1'b1, gateN: 1'b1, default: '0};

    ctrl_t s_reg;
    ctrl_t s_next;
    logic [ROW_W-1:0] reqRow;
    logic [COL_W-1:0] reqCol;
    logic rowMatch;

    assign reqRow = reqAddr[ROW_W+COL_W-1:COL_W];
    assign reqCol = reqAddr[COL_W-1:0];
    assign rowMatch = (reqRow == s_reg.row);

    // ------------------------------------------------------------
    // Request acceptance
    // ------------------------------------------------------------
    // A request is taken from idle, or while still selected after an access when it
    // stays inside the open row; a different row has to wait for deselect and pre-charge.
    always_comb begin
        unique case (s_reg.state)
            fram_host_pkg::ST_IDLE: reqReady = 1'b1;
            fram_host_pkg::ST_NEXT: reqReady = rowMatch; // see [R20]
            default: reqReady = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.rspValid = 1'b0;
        s_next.dqS1 = dataIn;
        s_next.dqS2 = s_reg.dqS1;
        s_next.cnt = s_reg.cnt + 16'h0001;
        unique case (s_reg.state)
            fram_host_pkg::ST_POWERUP: begin
                // Both selects stay inactive until the supply has settled.
                if (s_reg.cnt >= 16'(POWERUP_CYCLES - 1)) begin // see [R12]
                    s_next.state = fram_host_pkg::ST_IDLE;
                    s_next.selHi = 1'b1;
                    s_next.cnt = 16'h0000;
                end
            end
            fram_host_pkg::ST_IDLE: begin
                s_next.cnt = 16'h0000;
                if (reqValid) begin
                    // Select falls with the strobe high, so a write begins as a read
                    // and is strobe-controlled.
                    s_next.state = fram_host_pkg::ST_ADDR; // see [R02] see [R14]
                    s_next.selN = 1'b0;
                    s_next.gateN = reqWrite;
                    s_next.row = reqRow;
                    s_next.col = reqCol;
                    s_next.wdata = reqWdata;
                    s_next.isWrite = reqWrite;
                    s_next.pageHit = 1'b0;
                end
            end
            fram_host_pkg::ST_ADDR: begin
                if (s_reg.isWrite) begin
                    if (s_reg.cnt >= 16'(fram_host_pkg::ADDR_SETUP_CYC - 1)) begin
                        s_next.state = fram_host_pkg::ST_STROBE; // see [R15]
                        s_next.strobeN = 1'b0;
                        s_next.cnt = 16'h0000;
                    end
                end else if ((!s_reg.pageHit &&
                        s_reg.cnt >= 16'(fram_host_pkg::RANDOM_READ_CYC - 1)) ||
                        (s_reg.pageHit &&
                        s_reg.cnt >= 16'(fram_host_pkg::PAGE_READ_CYC - 1))) begin
                    s_next.rdata = s_reg.dqS2; // see [R17]
                    s_next.rspValid = 1'b1;
                    s_next.state = fram_host_pkg::ST_NEXT;
                end
            end
            fram_host_pkg::ST_STROBE: begin
                // Data is driven only after the memory has floated its outputs.
                if (s_reg.cnt >= 16'(fram_host_pkg::FLOAT_CYC - 1)) begin // see [R10]
                    s_next.dOe = 1'b1;
                    s_next.dOut = s_reg.wdata;
                end
                if (s_reg.cnt >= 16'(fram_host_pkg::STROBE_LOW_CYC - 1)) begin
                    // Strobe rises first and captures the byte; data is released on
                    // the same edge, before the memory may drive again.
                    s_next.strobeN = 1'b1; // see [R01] see [R04] see [R06] see [R11]
                    s_next.dOe = 1'b0;
                    s_next.rspValid = 1'b1;
                    s_next.state = fram_host_pkg::ST_NEXT;
                end
            end
            fram_host_pkg::ST_NEXT: begin
                s_next.cnt = 16'h0000;
                if (reqValid && rowMatch) begin
                    // Only the column moves, so the memory serves a page access.
                    s_next.state = fram_host_pkg::ST_ADDR; // see [R20] see [R07]
                    s_next.gateN = reqWrite;
                    s_next.col = reqCol; // see [R16] see [R03]
                    s_next.wdata = reqWdata;
                    s_next.isWrite = reqWrite;
                    s_next.pageHit = 1'b1;
                end else begin
                    s_next.state = fram_host_pkg::ST_PRECHARGE; // see [R08] see [R05]
                    s_next.selN = 1'b1; // see [R18]
                    s_next.gateN = 1'b1;
                end
            end
            fram_host_pkg::ST_PRECHARGE: begin
                if (s_reg.cnt >= 16'(fram_host_pkg::PRECHARGE_CYC - 1)) begin // see [R19]
                    s_next.state = fram_host_pkg::ST_IDLE;
                    s_next.cnt = 16'h0000;
                end
            end
        endcase
        // Row only moves from idle, long after the last strobe fall.
        if (s_next.row != s_reg.row) begin // see [R09]
            s_next.rowAge = 4'h0;
        end else if (s_reg.rowAge != 4'hF) begin
            s_next.rowAge = s_reg.rowAge + 4'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_reg <= CTRL_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign select_n = s_reg.selN;
    assign select_hi = s_reg.selHi;
    assign strobe_n = s_reg.strobeN;
    assign outputGate_n = s_reg.gateN;
    assign row_address_upper = s_reg.row;
    assign page_column_address = s_reg.col;
    assign dataOut = s_reg.dOut;
    assign dataOe = s_reg.dOe;
    assign rspValid = s_reg.rspValid;
    assign rspRdata = s_reg.rdata;
    // Power may be removed whenever the strobe is high; no settling wait is needed.
    assign powerSafe = s_reg.strobeN; // see [R13]

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    localparam int ROW_HIGH_MIN = fram_host_pkg::ROW_TO_HIGH_CYC;

    sequence strobeLowPulse;
        $fell(strobe_n) ##0 !strobe_n [*2];
    endsequence

    sequence strobeRise;
        $rose(strobe_n);
    endsequence

    a_strobe_low_width: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R07]
        $fell(strobe_n) |-> strobeLowPulse)
        else $error("Write strobe low shorter than two cycles.");

    a_row_to_rise: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R04]
        strobeRise |-> s_reg.rowAge >= 4'(ROW_HIGH_MIN))
        else $error("Strobe rose too soon after a row change.");

    a_select_before_rise: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R06]
        strobeRise |-> !$past(select_n, 1) && !$past(select_n, 2))
        else $error("Select not held two cycles before strobe rise.");

    a_deselect_after_fall: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R08]
        $rose(select_n) |-> strobe_n && $past(strobe_n))
        else $error("Deselect too close to the strobe fall.");

    a_row_hold_low: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R09]
        $changed(row_address_upper) |-> strobe_n && $past(strobe_n) && select_n == 1'b0
            ##0 $past(select_n))
        else $error("Row changed near a strobe fall or while selected.");

    a_data_float_wait: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R10]
        $fell(strobe_n) |-> !dataOe ##1 dataOe)
        else $error("Write data timing around strobe fall is wrong.");

    a_data_capture_edge: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R01]
        strobeRise |-> $past(dataOe) && !dataOe && $past(dataOut) == $past(s_reg.wdata))
        else $error("Write byte not on the bus at strobe rise.");

    a_column_setup_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R15]
        $fell(strobe_n) |-> $stable(page_column_address) ##1 $stable(page_column_address))
        else $error("Page column moved around the strobe fall.");

    a_precharge_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R19]
        $rose(select_n) |-> select_n [*2])
        else $error("Pre-charge time not held after deselect.");

    a_powerup_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R12]
        s_reg.state == fram_host_pkg::ST_POWERUP |-> select_n && !select_hi && strobe_n)
        else $error("Memory selected before power-up wait ended.");

    a_page_read_wait: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R17]
        $changed(page_column_address) && !select_n && outputGate_n == 1'b0
            |-> !rspValid [*3])
        else $error("Page read answered before access plus sync.");

endmodule

/* core/fram_host_pkg.sv */
// Constants and types for the ferroelectric SRAM-style port host controller.
// Contract
// [R01] Data captured at first select or strobe release
// [R02] Strobe write starts as read, row latched
// [R03] Page column address stable at least 15 ns
// [R04] Row change to strobe rise 105 ns
// [R05] Select asserted at least 70 ns per write
// [R06] Select asserted 70 ns before strobe rises
// [R07] Page write strobe cycle at least 40 ns
// [R08] Strobe fall to deselect at least 30 ns
// [R09] Row held 30 ns after strobe falls
// [R10] Memory floats data within 10 ns
// [R11] Memory drives data 5 ns after strobe rise
// [R12] First access 250 us after power up
// [R13] Power may drop once last strobe rose
// [R14] Select versus strobe order picks write type
// [R15] Page column setup 8 ns before strobe falls
// [R16] Page column hold 20 ns after strobe falls
// [R17] Page read data valid 40 ns after column
// [R18] Deselected memory ignores strobe and address
// [R19] Deselect holds pre-charge before next access
// [R20] Column-only change page read, row random
package fram_host_pkg;

    localparam int CLK_NS = 50;

    // Worst-case figures, taken at the lower supply range.
    localparam int WRITE_CYCLE_MIN_NS = 105;
    localparam int SELECT_ACTIVE_MIN_NS = 70;
    localparam int SELECT_TO_STROBE_HIGH_NS = 70;
    localparam int PRECHARGE_MIN_NS = 35;
    localparam int PAGE_WRITE_CYCLE_MIN_NS = 40;
    localparam int PAGE_ADDR_SETUP_NS = 8;
    localparam int PAGE_ADDR_HOLD_NS = 20;
    localparam int STROBE_LOW_TO_DESELECT_NS = 30;
    localparam int STROBE_LOW_TO_ROW_CHANGE_NS = 30;
    localparam int ROW_CHANGE_TO_STROBE_HIGH_NS = 105;
    localparam int STROBE_LOW_TO_FLOAT_NS = 10;
    localparam int DATA_SETUP_NS = 20;
    localparam int RANDOM_READ_ACCESS_NS = 105;
    localparam int PAGE_READ_ACCESS_NS = 40;
    localparam int POWERUP_TO_FIRST_ACCESS_US = 250;

    localparam int PRECHARGE_CYC = (PRECHARGE_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int ADDR_SETUP_CYC = (PAGE_ADDR_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int FLOAT_CYC = (STROBE_LOW_TO_FLOAT_NS + CLK_NS - 1) / CLK_NS;
    localparam int DATA_SETUP_CYC = (DATA_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int SEL_TO_HIGH_CYC = (SELECT_TO_STROBE_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int ROW_TO_HIGH_CYC = (ROW_CHANGE_TO_STROBE_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_LOW_CYC_A = (SEL_TO_HIGH_CYC > ROW_TO_HIGH_CYC - ADDR_SETUP_CYC)
        ? SEL_TO_HIGH_CYC : ROW_TO_HIGH_CYC - ADDR_SETUP_CYC;
    localparam int STROBE_LOW_CYC = (STROBE_LOW_CYC_A > FLOAT_CYC + DATA_SETUP_CYC)
        ? STROBE_LOW_CYC_A : FLOAT_CYC + DATA_SETUP_CYC;
    localparam int SYNC_CYC = 2;
    localparam int RANDOM_READ_CYC = (RANDOM_READ_ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
    localparam int PAGE_READ_CYC = (PAGE_READ_ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
    localparam int POWERUP_CYC = (POWERUP_TO_FIRST_ACCESS_US * 1000 + CLK_NS - 1) / CLK_NS;

    typedef enum logic [2:0] {
        ST_POWERUP,
        ST_IDLE,
        ST_ADDR,
        ST_STROBE,
        ST_NEXT,
        ST_PRECHARGE
    } state_t;

endpackage

/* verification/fram_mem_model.sv */
// Pin-level behavioural model of the byte-wide ferroelectric memory.
`timescale 1ns/1ps
module fram_mem_model (
    input wire logic select_n,
    input wire logic select_hi,
    input wire logic strobe_n,
    input wire logic outputGate_n,
    input wire logic [13:0] row_address_upper,
    input wire logic [2:0] page_column_address,
    input wire logic [7:0] busLevel,
    input wire logic slow,
    output logic [7:0] memData,
    output logic memOe,
    output int errCount = 0
);
    logic [7:0] mem [int];
    logic wrPend = 1'b0;
    logic [16:0] wrAddr;
    realtime selFall = -1.0e6;
    realtime selRise = -1.0e6;
    realtime stbFall = -1.0e6;
    realtime rowChg = -1.0e6;
    realtime colChg = -1.0e6;
    wire sel = !select_n && select_hi;
    wire [16:0] addr = {row_address_upper, page_column_address};

    task automatic flag(input realtime gap, input realtime need);
        if (gap < need) errCount++;
    endtask

    always @(negedge strobe_n) begin
        if (sel) begin
            flag($realtime - colChg, 8);
            flag($realtime - stbFall, 40);
            stbFall = $realtime;
            wrPend = 1'b1;
            wrAddr = addr;
        end
    end
    always @(posedge strobe_n) begin
        if (sel && wrPend) begin
            flag($realtime - selFall, 70);
            flag($realtime - rowChg, 105);
            mem[wrAddr] = busLevel;
            wrPend = 1'b0;
        end
    end
    always @(sel) begin
        if (sel) begin
            flag($realtime - selRise, 35);
            selFall = $realtime;
            wrPend = !strobe_n;
            wrAddr = addr;
        end else begin
            flag($realtime - selFall, 70);
            if (stbFall > selFall) flag($realtime - stbFall, 30);
            if (wrPend) mem[wrAddr] = busLevel;
            wrPend = 1'b0;
            selRise = $realtime;
        end
    end
    always @(row_address_upper) begin
        if (sel && !strobe_n) flag($realtime - stbFall, 30);
        rowChg = $realtime;
    end
    always @(page_column_address) begin
        if (sel) flag($realtime - colChg, 15);
        if (sel && !strobe_n) flag($realtime - stbFall, 20);
        colChg = $realtime;
    end
    // Unwritten places return a pattern so stale reads cannot pass unseen.
    always @(sel or outputGate_n or strobe_n or addr or slow) begin
        if (sel && !outputGate_n && strobe_n) begin
            memOe <= #(slow ? 30 : 6) 1'b1;
            memData <= #(slow ? 35 : 8) (mem.exists(addr) ? mem[addr] : ~addr[7:0]);
        end else begin
            memOe <= #5 1'b0;
        end
    end
endmodule

/* verification/nonvolatile_sram_port_cycles_test.sv */
// Self-checking bench for the ferroelectric memory host controller.
`timescale 1ns/1ps
module nonvolatile_sram_port_cycles_test;
    localparam int PWR = 4;
    logic sys_clk = 1'b0;
    logic rst_n, reqValid, reqWrite, reqReady, rspValid, powerSafe, slow, psNext;
    logic select_n, select_hi, strobe_n, outputGate_n, dataOe, memOe;
    logic [16:0] reqAddr;
    logic [7:0] reqWdata, rspRdata, dataOut, memData, busWire;
    logic [7:0] lastBus = 8'h00;
    logic [13:0] row_address_upper, row;
    logic [2:0] page_column_address;
    logic [16:0] addrs [6];
    logic [8:0] item;
    logic [8:0] expQ [$];
    logic [7:0] refMem [int];
    int failures, checks, cycles, modelErrs, n;

    fram_host #(.POWERUP_CYCLES(PWR)) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .reqValid(reqValid), .reqReady(reqReady),
        .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata), .rspValid(rspValid),
        .rspRdata(rspRdata), .powerSafe(powerSafe), .select_n(select_n),
        .select_hi(select_hi), .strobe_n(strobe_n), .outputGate_n(outputGate_n),
        .row_address_upper(row_address_upper), .page_column_address(page_column_address),
        .dataIn(busWire), .dataOut(dataOut), .dataOe(dataOe));
    fram_mem_model mem (
        .select_n(select_n), .select_hi(select_hi), .strobe_n(strobe_n),
        .outputGate_n(outputGate_n), .row_address_upper(row_address_upper),
        .page_column_address(page_column_address), .busLevel(busWire), .slow(slow),
        .memData(memData), .memOe(memOe), .errCount(modelErrs));

    // A released bus shows the inverse of its last driven level.
    assign #1 busWire = dataOe ? dataOut : (memOe ? memData : ~lastBus);

    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic send(input logic w, input logic [16:0] a, input logic [7:0] d);
        reqValid <= 1'b1;
        reqWrite <= w;
        reqAddr <= a;
        reqWdata <= d;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (reqReady !== 1'b1 && n < 100);
        if (n >= 100) check("requestTaken", 0, 1);
        if (w) begin
            refMem[a] = d;
            expQ.push_back({1'b0, d});
        end else begin
            expQ.push_back({1'b1, refMem[a]});
        end
    endtask

    task automatic idle();
        reqValid <= 1'b0;
        @(posedge sys_clk);
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            check("timeout", cycles, 0);
            results();
        end
    end

    always @(posedge sys_clk) begin
        if (psNext === 1'b1) check("powerSafe", powerSafe, 1);
        psNext = 1'b0;
        if (dataOe === 1'b1) check("busContention", memOe, 0);
        if (lastBus !== busWire && (dataOe || memOe)) lastBus <= busWire;
        if (rst_n === 1'b1 && rspValid === 1'b1) begin
            item = expQ.size() > 0 ? expQ.pop_front() : 9'h1FF;
            if (item[8]) begin
                check("readData", rspRdata, item[7:0]);
            end else begin
                check("strobeHigh", strobe_n, 1);
                psNext = 1'b1;
            end
        end
    end

    initial begin
        rst_n = 1'b0;
        reqValid = 1'b0;
        reqWrite = 1'b0;
        reqAddr = '0;
        reqWdata = '0;
        slow = 1'b0;
        psNext = 1'b0;
        void'($urandom(32'h885EB20F));
        repeat (16) @(posedge sys_clk);
        check("resetPins", {select_n, select_hi, strobe_n, dataOe}, 4'hA);
        rst_n <= 1'b1;
        for (int i = 0; i < PWR; i++) begin
            @(posedge sys_clk);
            check("readyInPowerup", {reqReady, select_hi}, 0);
        end
        $display("test powerup done");
        for (int i = 0; i < 6; i++) begin
            addrs[i] = 17'($urandom);
            send(1'b1, addrs[i], 8'($urandom));
            idle();
        end
        $display("test random writes done");
        for (int s = 0; s < 2; s++) begin
            slow <= s[0];
            row = 14'($urandom);
            for (int c = 0; c < 8; c++) send(1'b1, {row, 3'(c)}, 8'($urandom));
            for (int c = 7; c >= 0; c--) send(1'b0, {row, 3'(c)}, 8'h00);
            for (int i = 5; i >= 0; i--) send(1'b0, addrs[i], 8'h00);
            idle();
            $display("test page and random reads %0d done", s);
        end
        n = 0;
        while (expQ.size() > 0 && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
        repeat (4) @(posedge sys_clk);
        check("pending", expQ.size(), 0);
        check("pinTiming", modelErrs, 0);
        results();
    end
endmodule
